/* File: logic/sws_consts.svh */
`ifndef SWS_CONSTS_SVH
`define SWS_CONSTS_SVH

// command block register select codes, the stream write opcode, the sector count limit and the feature bit
`define SWS_TF_FEATURE  3'h1
`define SWS_TF_COUNT    3'h2
`define SWS_TF_LBA_LO   3'h3
`define SWS_TF_LBA_MID  3'h4
`define SWS_TF_LBA_HI   3'h5
`define SWS_TF_COMMAND  3'h7
`define SWS_OP_WSTREAM  8'h3b
`define SWS_MAX_SECT    17'h10000
`define SWS_FEAT_CONT   6
// error register fields
`define SWS_ERR_CRC     7
`define SWS_ERR_IDNF    4
`define SWS_ERR_ABRT    2
`define SWS_ERR_TMO     0
// status register fields
`define SWS_ST_BSY      7
`define SWS_ST_RDY      6
`define SWS_ST_STRM     5
`define SWS_ST_DRQ      3
`define SWS_ST_ERR      0
// timing
`define SWS_CLK_PERIOD_NS 100
`define SWS_US_NS         1000
`define SWS_CYC_PER_US    (`SWS_US_NS / `SWS_CLK_PERIOD_NS)
// data path
`define SWS_DATA_W      16
`define SWS_BUF_DEPTH   2
`endif

/* File: logic/sws_pkg.sv */
package sws_pkg;
	typedef enum logic [0:0] {
		SWS_IDLE = 1'b0,
		SWS_XFER = 1'b1
	} sws_state_e;
	typedef logic [47:0] sws_lba_t;
	typedef logic [16:0] sws_count_t;
endpackage

/* File: logic/sws_buf_if.sv */
`include "sws_consts.svh"
interface sws_buf_if;
	logic                    in_valid;
	logic [`SWS_DATA_W-1:0]  in_data;
	logic                    room_next;
	logic                    out_valid;
	logic [`SWS_DATA_W-1:0]  out_data;
	logic                    out_ready;
	logic                    flush;
	modport buf_side (input in_valid, input in_data, output room_next,
		output out_valid, output out_data, input out_ready, input flush);
	modport ctl_side (output in_valid, output in_data, input room_next,
		input out_valid, input out_data, output out_ready, output flush);
endinterface

/* File: logic/sws_buf.sv */
`include "sws_consts.svh"
module sws_buf (
	input  wire logic    clk,
	input  wire logic    rst,
	input  wire logic    ce,
	sws_buf_if.buf_side  b
);
	logic [1:0]              cnt_q;
	logic [1:0]              cnt_d;
	logic [`SWS_DATA_W-1:0]  e0_q;
	logic [`SWS_DATA_W-1:0]  e1_q;
	logic                    vld_q;
	logic                    push;
	logic                    pop;

	// head entry is a flop so the media side sees registered data
	assign push = b.in_valid;
	assign pop  = vld_q && b.out_ready;
	assign b.out_valid = vld_q;
	assign b.out_data  = e0_q;
	assign b.room_next = (cnt_d != 2'(`SWS_BUF_DEPTH));

	// occupancy; the writer only pushes when room was promised
	always_comb begin
		cnt_d = cnt_q;
		if (b.flush)
			cnt_d = 2'h0;
		else if (push && !pop)
			cnt_d = cnt_q + 2'h1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'h1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 2'h0;
			vld_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			vld_q <= (cnt_d != 2'h0);
		end
	end

	// shift storage: pop moves entry one forward
	always_ff @(posedge clk) begin
		if (rst) begin
			e0_q <= 16'h0;
			e1_q <= 16'h0;
		end else if (ce) begin
			if (pop) begin
				e0_q <= (push && cnt_q == 2'h1) ? b.in_data : e1_q;
				if (push && cnt_q == 2'h2)
					e1_q <= b.in_data;
			end else if (push) begin
				if (cnt_q == 2'h0)
					e0_q <= b.in_data;
				else
					e1_q <= b.in_data;
			end
		end
	end
endmodule // sws_buf

/* File: logic/sws_top.sv */
`include "sws_consts.svh"
module sws_top (
	input  wire logic                    CORE_CLK,
	input  wire logic                    SYS_RST,
	input  wire logic                    CLK_EN,
	input  wire logic                    TF_WR,
	input  wire logic [2:0]              TF_ADDR,
	input  wire logic [7:0]              TF_WDATA,
	input  wire logic                    HIGH_ORDER_BYTE_SELECT,
	input  wire logic [31:0]             TIME_UNIT_US,
	input  wire logic                    DIN_VALID,
	input  wire logic [`SWS_DATA_W-1:0]  DIN_DATA,
	input  wire logic                    DIN_CRC_ERR,
	input  wire logic                    MED_READY,
	input  wire logic                    MED_ERR,
	input  wire logic                    MED_ERR_ABRT,
	output logic                         DIN_READY,
	output logic                         MED_VALID,
	output logic [`SWS_DATA_W-1:0]       MED_DATA,
	output logic [7:0]                   ERROR_REG,
	output logic [7:0]                   STATUS_REG,
	output logic [7:0]                   LBA_LO,
	output logic [7:0]                   LBA_MID,
	output logic [7:0]                   LBA_HI,
	output logic                         CMD_DONE
);
	sws_pkg::sws_state_e  st_q;
	sws_pkg::sws_state_e  st_d;
	logic [7:0]           feat_q [2];
	logic [7:0]           cnt_q  [2];
	logic [7:0]           lo_q   [2];
	logic [7:0]           mid_q  [2];
	logic [7:0]           hi_q   [2];
	sws_pkg::sws_lba_t    base_q;
	sws_pkg::sws_count_t  tot_q;
	sws_pkg::sws_count_t  tot_d;
	sws_pkg::sws_count_t  acc_q;
	sws_pkg::sws_count_t  acc_d;
	sws_pkg::sws_count_t  sent_q;
	logic                 cont_q;
	logic [39:0]          lim_q;
	logic                 lim_en_q;
	logic [39:0]          us_q;
	logic [3:0]           pre_q;
	logic                 rdy_q;
	logic                 done_q;
	logic                 crc_q;
	logic                 idnf_q;
	logic                 abrt_q;
	logic                 tmo_q;
	logic                 strm_q;
	logic                 errb_q;
	logic                 have_q;
	sws_pkg::sws_lba_t    elba_q;
	logic                 start;
	logic                 host_take;
	logic                 med_take;
	logic                 ev_crc;
	logic                 ev_med;
	logic                 timeout;
	logic                 fatal;
	logic                 last_out;
	logic                 stop;
	sws_pkg::sws_count_t  req_cnt;

	sws_buf_if bi ();

	sws_buf u_buf (
		.clk (CORE_CLK),
		.rst (SYS_RST),
		.ce  (CLK_EN),
		.b   (bi.buf_side)
	);

	// address of the n-th sector of the command
	function automatic sws_pkg::sws_lba_t lba_at(input sws_pkg::sws_lba_t b,
		input sws_pkg::sws_count_t n);
		lba_at = b + {31'h0, n};
	endfunction

	// extended count from the current/previous pair, zero meaning the maximum
	function automatic sws_pkg::sws_count_t ext_count(input logic [7:0] hi,
		input logic [7:0] lo);
		ext_count = ({hi, lo} == 16'h0) ? `SWS_MAX_SECT : {1'b0, hi, lo};
	endfunction

	assign start = TF_WR && (TF_ADDR == `SWS_TF_COMMAND)
		&& (TF_WDATA == `SWS_OP_WSTREAM) && (st_q == sws_pkg::SWS_IDLE);
	assign req_cnt   = ext_count(cnt_q[1], cnt_q[0]);
	assign host_take = DIN_VALID && rdy_q;
	assign med_take  = bi.out_valid && MED_READY;
	assign ev_crc    = host_take && DIN_CRC_ERR;
	assign ev_med    = med_take && MED_ERR;
	assign timeout   = (st_q == sws_pkg::SWS_XFER) && lim_en_q && (us_q >= lim_q);
	// without continuous-write the first error ends the command
	assign fatal     = (ev_crc || ev_med) && !cont_q;
	assign last_out  = med_take && (sent_q + 17'h1 == tot_q);
	assign stop      = (st_q == sws_pkg::SWS_XFER) && (timeout || fatal || last_out);

	// buffer hookup; on a stop the words still held are dropped
	assign bi.in_valid  = host_take;
	assign bi.in_data   = DIN_DATA;
	assign bi.out_ready = MED_READY;
	assign bi.flush     = stop;
	assign MED_VALID    = bi.out_valid;
	assign MED_DATA     = bi.out_data;
	assign DIN_READY    = rdy_q;
	assign CMD_DONE     = done_q;

	// next state and next counters, needed ahead for the ready flop
	always_comb begin
		st_d  = st_q;
		tot_d = tot_q;
		acc_d = acc_q;
		if (start) begin
			st_d  = sws_pkg::SWS_XFER;
			tot_d = req_cnt;
			acc_d = 17'h0;
		end else if (stop) begin
			st_d = sws_pkg::SWS_IDLE;
		end else if (host_take) begin
			acc_d = acc_q + 17'h1;
		end
	end

	// command block writes other than the command register shift current into previous; ignored while busy
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < 2; i++) begin
				feat_q[i] <= 8'h0;
				cnt_q[i]  <= 8'h0;
				lo_q[i]   <= 8'h0;
				mid_q[i]  <= 8'h0;
				hi_q[i]   <= 8'h0;
			end
		end else if (CLK_EN && TF_WR && st_q == sws_pkg::SWS_IDLE) begin
			case (TF_ADDR)
				`SWS_TF_FEATURE: begin
					feat_q[1] <= feat_q[0];
					feat_q[0] <= TF_WDATA;
				end
				`SWS_TF_COUNT: begin
					cnt_q[1] <= cnt_q[0];
					cnt_q[0] <= TF_WDATA;
				end
				`SWS_TF_LBA_LO: begin
					lo_q[1] <= lo_q[0];
					lo_q[0] <= TF_WDATA;
				end
				`SWS_TF_LBA_MID: begin
					mid_q[1] <= mid_q[0];
					mid_q[0] <= TF_WDATA;
				end
				`SWS_TF_LBA_HI: begin
					hi_q[1] <= hi_q[0];
					hi_q[0] <= TF_WDATA;
				end
				default: ;
			endcase
		end
	end

	// command state, parameters latched at the command write
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			st_q     <= sws_pkg::SWS_IDLE;
			tot_q    <= 17'h0;
			base_q   <= 48'h0;
			cont_q   <= 1'b0;
			lim_q    <= 40'h0;
			lim_en_q <= 1'b0;
		end else if (CLK_EN) begin
			st_q  <= st_d;
			tot_q <= tot_d;
			if (start) begin
				base_q   <= {hi_q[1], mid_q[1], lo_q[1], hi_q[0], mid_q[0], lo_q[0]};
				cont_q   <= feat_q[0][`SWS_FEAT_CONT];
				lim_q    <= feat_q[1] * TIME_UNIT_US;
				lim_en_q <= (feat_q[1] != 8'h0); // zero means no limit here
			end
		end
	end

	// sector counters on both sides of the buffer
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			acc_q  <= 17'h0;
			sent_q <= 17'h0;
		end else if (CLK_EN) begin
			acc_q <= acc_d;
			if (start)
				sent_q <= 17'h0;
			else if (med_take)
				sent_q <= sent_q + 17'h1;
		end
	end

	// host may push while sectors remain and the buffer promises room
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			rdy_q <= 1'b0;
		else if (CLK_EN)
			rdy_q <= (st_d == sws_pkg::SWS_XFER) && (acc_d < tot_d) && bi.room_next;
	end

	// elapsed time in microseconds from the command write
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			pre_q <= 4'h0;
			us_q  <= 40'h0;
		end else if (CLK_EN) begin
			if (start) begin
				pre_q <= 4'h0;
				us_q  <= 40'h0;
			end else if (st_q == sws_pkg::SWS_XFER) begin
				if (pre_q == 4'(`SWS_CYC_PER_US - 1)) begin
					pre_q <= 4'h0;
					us_q  <= us_q + 40'h1;
				end else begin
					pre_q <= pre_q + 4'h1;
				end
			end
		end
	end

	// error log; a command write clears it, events during the run set it
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			crc_q  <= 1'b0;
			idnf_q <= 1'b0;
			abrt_q <= 1'b0;
			tmo_q  <= 1'b0;
			strm_q <= 1'b0;
			errb_q <= 1'b0;
		end else if (CLK_EN) begin
			if (start) begin
				crc_q  <= 1'b0;
				idnf_q <= 1'b0;
				abrt_q <= 1'b0;
				tmo_q  <= 1'b0;
				strm_q <= 1'b0;
				errb_q <= 1'b0;
			end else if (st_q == sws_pkg::SWS_XFER) begin
				if (ev_crc)
					crc_q <= 1'b1;
				if (ev_med && MED_ERR_ABRT)
					abrt_q <= 1'b1;
				if (ev_med && !MED_ERR_ABRT)
					idnf_q <= 1'b1;
				if (timeout)
					tmo_q <= 1'b1;
				// continuous-write reports stream error, never the error bit
				if (cont_q && (ev_crc || ev_med || timeout))
					strm_q <= 1'b1;
				if (!cont_q && (fatal || timeout))
					errb_q <= 1'b1;
			end
		end
	end

	// address of the first unrecoverable sector; later errors do not move it
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			have_q <= 1'b0;
			elba_q <= 48'h0;
		end else if (CLK_EN) begin
			if (start) begin
				have_q <= 1'b0;
				elba_q <= 48'h0;
			end else if (st_q == sws_pkg::SWS_XFER && !have_q) begin
				// the media side is older than the host side, so it wins
				if (ev_med) begin
					have_q <= 1'b1;
					elba_q <= lba_at(base_q, sent_q);
				end else if (ev_crc) begin
					have_q <= 1'b1;
					elba_q <= lba_at(base_q, acc_q);
				end
			end
		end
	end

	// completion pulse, one cycle as the command ends
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			done_q <= 1'b0;
		else if (CLK_EN)
			done_q <= stop;
	end

	// read-side registers, refreshed every cycle
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ERROR_REG  <= 8'h0;
			STATUS_REG <= 8'h0;
			LBA_LO     <= 8'h0;
			LBA_MID    <= 8'h0;
			LBA_HI     <= 8'h0;
		end else if (CLK_EN) begin
			ERROR_REG <= 8'h0;
			ERROR_REG[`SWS_ERR_CRC]  <= crc_q;
			ERROR_REG[`SWS_ERR_IDNF] <= idnf_q;
			ERROR_REG[`SWS_ERR_ABRT] <= abrt_q;
			ERROR_REG[`SWS_ERR_TMO]  <= tmo_q;
			STATUS_REG <= 8'h0;
			STATUS_REG[`SWS_ST_BSY] <= (st_q == sws_pkg::SWS_XFER);
			STATUS_REG[`SWS_ST_RDY] <= 1'b1;
			STATUS_REG[`SWS_ST_STRM] <= strm_q;
			STATUS_REG[`SWS_ST_DRQ] <= (st_q == sws_pkg::SWS_XFER) && (acc_q < tot_q);
			STATUS_REG[`SWS_ST_ERR] <= errb_q;
			if (HIGH_ORDER_BYTE_SELECT) begin
				LBA_LO  <= elba_q[31:24];
				LBA_MID <= elba_q[39:32];
				LBA_HI  <= elba_q[47:40];
			end else begin
				LBA_LO  <= elba_q[7:0];
				LBA_MID <= elba_q[15:8];
				LBA_HI  <= elba_q[23:16];
			end
		end
	end
endmodule // sws_top

/* File: verif/sws_checker.sv */
`include "sws_consts.svh"
module sws_checker (
	input wire logic	CORE_CLK,
	input wire logic	SYS_RST,
	input wire logic	CLK_EN,
	input wire logic	TF_WR,
	input wire logic [2:0]	TF_ADDR,
	input wire logic [7:0]	TF_WDATA,
	input wire logic [31:0]	TIME_UNIT_US,
	input wire logic	DIN_VALID,
	input wire logic	DIN_READY,
	input wire logic	MED_VALID,
	input wire logic	MED_READY,
	input wire logic [7:0]	ERROR_REG,
	input wire logic [7:0]	STATUS_REG,
	input wire logic	CMD_DONE
);
	logic [15:0]	ft_q;
	logic [15:0]	cn_q;
	logic [47:0]	lim_q;
	logic [47:0]	cyc_q;
	logic [16:0]	md_q;
	logic [16:0]	dn_q;
	logic [16:0]	req;
	logic		st;
	logic		idle;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	// a start is a 3bh write seen while idle; writes in a run are ignored
	assign idle = !STATUS_REG[`SWS_ST_BSY];
	assign st = CLK_EN && TF_WR && TF_ADDR == `SWS_TF_COMMAND && TF_WDATA == `SWS_OP_WSTREAM && idle;
	assign req = (cn_q == 16'h0) ? `SWS_MAX_SECT : {1'b0, cn_q};
	// shadow of field writes and of traffic since the last start
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ft_q <= 16'h0;
			cn_q <= 16'h0;
			lim_q <= 48'h0;
			cyc_q <= 48'h0;
			md_q <= 17'h0;
			dn_q <= 17'h0;
		end else if (CLK_EN) begin
			if (TF_WR && idle && TF_ADDR == `SWS_TF_FEATURE)
				ft_q <= {ft_q[7:0], TF_WDATA};
			if (TF_WR && idle && TF_ADDR == `SWS_TF_COUNT)
				cn_q <= {cn_q[7:0], TF_WDATA};
			if (st)
				lim_q <= ft_q[15:8] * TIME_UNIT_US * `SWS_CYC_PER_US;
			cyc_q <= st ? 48'h0 : cyc_q + 48'h1;
			md_q <= st ? 17'h0 : md_q + 17'(MED_VALID && MED_READY);
			dn_q <= st ? 17'h0 : dn_q + 17'(DIN_VALID && DIN_READY);
		end
	end
	start_busy_a: assert property (st |-> ##2 !idle)
		else $error("busy missing after start");
	err_zero_a: assert property ((ERROR_REG & 8'h6a) == 8'h0)
		else $error("reserved error bit set");
	stream_err_a: assert property (!(STATUS_REG[`SWS_ST_STRM] && STATUS_REG[`SWS_ST_ERR]))
		else $error("stream error with err");
	done_idle_a: assert property (CMD_DONE |-> ##1 idle)
		else $error("busy after command end");
	sect_count_a: assert property ($past(CMD_DONE) && !STATUS_REG[`SWS_ST_ERR]
		&& !ERROR_REG[`SWS_ERR_TMO] |-> md_q == req) else $error("sector count wrong");
	din_max_a: assert property (!idle |-> dn_q <= req)
		else $error("sector taken past count");
	timeout_late_a: assert property ($rose(ERROR_REG[`SWS_ERR_TMO])
		|-> lim_q != 48'h0 && cyc_q >= lim_q - 48'h1) else $error("early timeout");
	timeout_bound_a: assert property (lim_q != 48'h0 && cyc_q == lim_q + 48'h6 |-> idle)
		else $error("time limit not enforced");
endmodule // sws_checker
bind sws_top sws_checker u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
	.TF_WR(TF_WR), .TF_ADDR(TF_ADDR), .TF_WDATA(TF_WDATA), .TIME_UNIT_US(TIME_UNIT_US),
	.DIN_VALID(DIN_VALID), .DIN_READY(DIN_READY), .MED_VALID(MED_VALID),
	.MED_READY(MED_READY), .ERROR_REG(ERROR_REG), .STATUS_REG(STATUS_REG),
	.CMD_DONE(CMD_DONE));

/* File: verif/sws_media_model.sv */
module sws_media_model (
	input wire logic	clk,
	input wire logic	rst,
	input wire logic	med_valid,
	input wire logic	stop,
	input wire logic	slow,
	input wire logic [31:0]	err_at,
	input wire logic	abrt,
	output logic		med_ready,
	output logic		med_err,
	output logic		med_err_abrt,
	output logic [31:0]	n_acc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	tog_q;
	// ready moves only after an edge; slow mode offers it every other cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			tog_q <= 1'b0;
			med_ready <= 1'b0;
			n_acc <= 32'h0;
		end else begin
			tog_q <= ~tog_q;
			med_ready <= !stop && (!slow || tog_q);
			if (med_valid && med_ready)
				n_acc <= n_acc + 32'h1;
		end
	end
	// a failure only means something on a sector being accepted
	assign med_err = med_ready && med_valid && (n_acc == err_at);
	assign med_err_abrt = abrt;
endmodule // sws_media_model

/* File: verif/stream_write_command_tb_top.sv */
`include "sws_consts.svh"
module stream_write_command_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic			CORE_CLK, SYS_RST, TF_WR, HIGH_ORDER_BYTE_SELECT, DIN_VALID, DIN_CRC_ERR;
	logic			DIN_READY, MED_VALID, MED_READY, MED_ERR, MED_ERR_ABRT, CMD_DONE;
	logic			stop, slow, abrt;
	logic [2:0]		TF_ADDR;
	logic [7:0]		TF_WDATA, ERROR_REG, STATUS_REG, LBA_LO, LBA_MID, LBA_HI;
	logic [31:0]		TIME_UNIT_US, err_at, n_acc;
	logic [`SWS_DATA_W-1:0]	DIN_DATA, MED_DATA;
	int			n_errors, checked, n_done, d0, taken, m0;
	localparam logic [47:0]	LBA0 = 48'h123456789abc;
	sws_top dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(1'b1), .TF_WR(TF_WR),
		.TF_ADDR(TF_ADDR), .TF_WDATA(TF_WDATA),
		.HIGH_ORDER_BYTE_SELECT(HIGH_ORDER_BYTE_SELECT),
		.TIME_UNIT_US(TIME_UNIT_US), .DIN_VALID(DIN_VALID), .DIN_DATA(DIN_DATA),
		.DIN_CRC_ERR(DIN_CRC_ERR), .MED_READY(MED_READY), .MED_ERR(MED_ERR),
		.MED_ERR_ABRT(MED_ERR_ABRT), .DIN_READY(DIN_READY), .MED_VALID(MED_VALID),
		.MED_DATA(MED_DATA), .ERROR_REG(ERROR_REG), .STATUS_REG(STATUS_REG),
		.LBA_LO(LBA_LO), .LBA_MID(LBA_MID), .LBA_HI(LBA_HI), .CMD_DONE(CMD_DONE));
	sws_media_model u_med (.clk(CORE_CLK), .rst(SYS_RST), .med_valid(MED_VALID),
		.stop(stop), .slow(slow), .err_at(err_at), .abrt(abrt), .med_ready(MED_READY),
		.med_err(MED_ERR), .med_err_abrt(MED_ERR_ABRT), .n_acc(n_acc));
	initial begin
		CORE_CLK = 1'b0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end
	// end pulses are counted so tasks can see one that came mid-transfer
	always @(posedge CORE_CLK)
		if (CMD_DONE === 1'b1)
			n_done <= n_done + 1;
	// media words must keep host order: the word of sector k carries k
	always @(posedge CORE_CLK)
		if (!SYS_RST && MED_VALID === 1'b1 && MED_READY === 1'b1) begin
			checked++;
			if (MED_DATA !== 16'(n_acc - m0)) begin
				n_errors++;
				$display("[FAIL] media data exp %h got %h", 16'(n_acc - m0), MED_DATA);
			end
		end
	task complete_run;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// one register write: strobe for one edge, then a quiet edge
	task wr(input logic [2:0] ad, input logic [7:0] d);
		TF_WR <= 1'b1;
		TF_ADDR <= ad;
		TF_WDATA <= d;
		@(posedge CORE_CLK);
		TF_WR <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	task cmd(input logic [7:0] fp, fc, input logic [15:0] cnt, input logic [7:0] op);
		wr(`SWS_TF_FEATURE, fp);
		wr(`SWS_TF_FEATURE, fc);
		wr(`SWS_TF_COUNT, cnt[15:8]);
		wr(`SWS_TF_COUNT, cnt[7:0]);
		wr(`SWS_TF_LBA_LO, LBA0[31:24]);
		wr(`SWS_TF_LBA_LO, LBA0[7:0]);
		wr(`SWS_TF_LBA_MID, LBA0[39:32]);
		wr(`SWS_TF_LBA_MID, LBA0[15:8]);
		wr(`SWS_TF_LBA_HI, LBA0[47:40]);
		wr(`SWS_TF_LBA_HI, LBA0[23:16]);
		wr(`SWS_TF_COMMAND, op);
	endtask
	// a beat is held until taken; a stop of the command ends the offer
	task send(input int i0, n, bad, lim);
		int i;
		int k;
		i = i0;
		k = 0;
		while (i < n && k < lim && n_done == d0) begin
			DIN_VALID <= 1'b1;
			DIN_DATA <= i[15:0];
			DIN_CRC_ERR <= (i == bad);
			@(posedge CORE_CLK);
			k++;
			if (DIN_READY === 1'b1)
				i++;
		end
		if (i == n || n_done != d0)
			DIN_VALID <= 1'b0;
		taken = i - i0;
	endtask
	task wait_done;
		int k;
		k = 0;
		while (n_done == d0 && k < 5000) begin
			@(posedge CORE_CLK);
			k++;
		end
		if (n_done == d0) begin
			n_errors++;
			$display("[FAIL] cmd_done exp 1 got 0");
			complete_run;
		end
		repeat (3) @(posedge CORE_CLK);
	endtask
	task run(input logic [7:0] fp, fc, input logic [15:0] cnt, input int ns, bad, ei,
		input logic ab, input logic [7:0] es, ee, input int en, input logic [47:0] el);
		int a0;
		a0 = n_acc;
		m0 = n_acc;
		d0 = n_done;
		err_at <= (ei < 0) ? 32'hffffffff : n_acc + ei;
		abrt <= ab;
		cmd(fp, fc, cnt, `SWS_OP_WSTREAM);
		send(0, ns, bad, ns + 3000);
		// an offer that ran out of time while the command still runs is a hang
		if (n_done == d0 && taken != ns) begin
			n_errors++;
			$display("[FAIL] sectors offered exp %0d got %0d", ns, taken);
			complete_run;
		end
		wait_done;
		chk("status", es, STATUS_REG);
		chk("error", ee, ERROR_REG);
		chk("sectors", en, n_acc - a0);
		if (el !== 48'h0) begin
			chk("lba low", el[23:0], {LBA_HI, LBA_MID, LBA_LO});
			HIGH_ORDER_BYTE_SELECT <= 1'b1;
			repeat (2) @(posedge CORE_CLK);
			chk("lba high", el[47:24], {LBA_HI, LBA_MID, LBA_LO});
			HIGH_ORDER_BYTE_SELECT <= 1'b0;
		end
	endtask
	initial begin
		SYS_RST = 1'b1;
		TF_WR = 1'b0;
		TF_ADDR = 3'h0;
		TF_WDATA = 8'h0;
		HIGH_ORDER_BYTE_SELECT = 1'b0;
		TIME_UNIT_US = 32'h1;
		DIN_VALID = 1'b0;
		DIN_DATA = '0;
		DIN_CRC_ERR = 1'b0;
		stop = 1'b0;
		slow = 1'b0;
		abrt = 1'b0;
		err_at = 32'hffffffff;
		repeat (10) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		chk("reset error", 8'h0, ERROR_REG);
		wr(`SWS_TF_COMMAND, 8'h35);
		repeat (3) @(posedge CORE_CLK);
		chk("foreign opcode", 8'h40, STATUS_REG);
		// media stalled: the buffer takes two sectors, then refuses
		stop <= 1'b1;
		d0 = n_done;
		m0 = n_acc;
		cmd(8'h0, 8'h0, 16'h3, `SWS_OP_WSTREAM);
		send(0, 3, -1, 12);
		chk("buffered", 2, taken);
		stop <= 1'b0;
		slow <= 1'b1;
		send(2, 3, -1, 3000);
		chk("stall rest", 1, taken);
		wait_done;
		chk("stall status", 8'h40, STATUS_REG);
		run(8'h0, 8'h0, 16'h102, 258, -1, -1, 0, 8'h40, 8'h0, 258, 48'h0);
		slow <= 1'b0;
		run(8'h0, 8'h40, 16'h4, 4, -1, 1, 1, 8'h60, 8'h04, 4, LBA0 + 1);
		run(8'h0, 8'h40, 16'h4, 4, 2, -1, 0, 8'h60, 8'h80, 4, LBA0 + 2);
		run(8'h0, 8'h40, 16'h3, 3, -1, 0, 0, 8'h60, 8'h10, 3, LBA0);
		run(8'h0, 8'h0, 16'h4, 4, -1, 0, 0, 8'h41, 8'h10, 1, LBA0);
		run(8'h1, 8'h40, 16'h2, 0, -1, -1, 0, 8'h60, 8'h01, 0, 48'h0);
		run(8'h1, 8'h0, 16'h2, 0, -1, -1, 0, 8'h41, 8'h01, 0, 48'h0);
		run(8'h0, 8'h0, 16'h0, 65536, -1, -1, 0, 8'h40, 8'h0, 65536, 48'h0);
		complete_run;
	end
endmodule // stream_write_command_tb_top
